// ---- eda_consts.vh ----
// Constants for the EEPROM data access block
`ifndef EDA_CONSTS_VH
`define EDA_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus
`define EDA_ADDR_W 8
`define EDA_OFS_CONTROL 8'h00
`define EDA_OFS_UNLOCK 8'h04
`define EDA_OFS_LOCATION 8'h08
`define EDA_OFS_VALUE 8'h0C
`define EDA_OFS_IRQ_STATUS 8'h10
`define EDA_OFS_IRQ_MASK 8'h14

// Control register field positions
`define EDA_BIT_SPACE 7
`define EDA_BIT_ABORT 3
`define EDA_BIT_PERMIT 2
`define EDA_BIT_PGO 1
`define EDA_BIT_FGO 0

// Interrupt status field positions
`define EDA_IRQ_DONE 0
`define EDA_IRQ_ABORT 1
`define EDA_IRQ_W 2

// Unlock keys and sequence states
`define EDA_KEY_FIRST 8'h55
`define EDA_KEY_SECOND 8'hAA
`define EDA_UNL_IDLE 2'h0
`define EDA_UNL_FIRST 2'h1
`define EDA_UNL_ARMED 2'h2

// Data memory geometry and write cycle length
`define EDA_MEM_AW 8
`define EDA_MEM_DEPTH 256
`define EDA_WR_CYCLES 1000
`define EDA_CNT_W 16

// AXI responses
`define EDA_RESP_OKAY 2'h0
`define EDA_RESP_SLVERR 2'h2

`endif

// ---- eda_nvmem.v ----
// Data memory array with timed write cycle
`timescale 1ns/100ps
`default_nettype none
`include "eda_consts.vh"
module eda_nvmem #(
	parameter WR_CYCLES = `EDA_WR_CYCLES
) (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Write cycle control
	input wire start,
	input wire abort,
	input wire [`EDA_MEM_AW-1:0] wr_addr,
	input wire [7:0] wr_data,
	output reg busy,
	output reg done,
	// Read port
	input wire [`EDA_MEM_AW-1:0] rd_addr,
	output wire [7:0] rd_data
);
	reg [7:0] mem [0:`EDA_MEM_DEPTH-1];
	reg [`EDA_CNT_W-1:0] cnt;
	reg [`EDA_MEM_AW-1:0] addr_q;
	reg [7:0] data_q;

	localparam integer LAST_FULL = WR_CYCLES - 1;
	localparam [`EDA_CNT_W-1:0] LAST = LAST_FULL[`EDA_CNT_W-1:0];

	assign rd_data = mem[rd_addr];

	always @(posedge core_clk) begin
		if (!nrst) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= {`EDA_CNT_W{1'b0}};
			addr_q <= {`EDA_MEM_AW{1'b0}};
			data_q <= 8'h00;
		end else begin
			done <= 1'b0;
			if (abort) begin
				// Cell write is dropped; caller records the abort
				busy <= 1'b0;
			end else if (busy) begin
				if (cnt == LAST) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt <= cnt + {{(`EDA_CNT_W-1){1'b0}}, 1'b1};
				end
			end else if (start) begin
				busy <= 1'b1;
				cnt <= {`EDA_CNT_W{1'b0}};
				addr_q <= wr_addr;
				data_q <= wr_data;
			end
		end
	end

	always @(posedge core_clk) begin
		if (nrst && busy && !abort && cnt == LAST) begin
			mem[addr_q] <= data_q;
		end
	end
endmodule
`default_nettype wire

// ---- eda_top.v ----
// EEPROM data access control with AXI4-Lite register slave
//
// How it works
// - Bit 7 selects program or data space
// - Space select frozen while read/write busy
// - Reset or watchdog during data-space write sets abort
// - Permit bit gates every EEPROM write
// - Program-go starts write, hardware clears it
// - Software writing zero to program-go ignored
// - Fetch-go starts read, set-only, hardware clears
// - Read byte appears next cycle
// - Value register holds until read or write
// - Permit must precede program-go write
// - Clearing permit never aborts running write
// - 55h, AAh, then program-go unlocks write
// - Data-space write end clears program-go, sets done flag
`timescale 1ns/100ps
`default_nettype none
`include "eda_consts.vh"
module eda_top #(
	parameter WR_CYCLES = `EDA_WR_CYCLES
) (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// External reset pin or watchdog reset event
	input wire warm_rst,
	// AXI4-Lite write address
	input wire [`EDA_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [`EDA_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Program memory route
	output reg prog_rd_req,
	output reg prog_wr_req,
	output reg [7:0] prog_addr,
	output reg [7:0] prog_wdata,
	input wire [7:0] prog_rdata,
	// Interrupt
	output wire irq
);
	reg aw_got;
	reg w_got;
	reg [`EDA_ADDR_W-1:0] aw_addr;
	reg [7:0] w_byte;
	reg w_lane;
	reg space_select;
	reg abort_flag;
	reg cycle_permit;
	reg pgo;
	reg fgo;
	reg [1:0] unlock_state;
	reg [7:0] nv_location_reg;
	reg [7:0] nv_value_reg;
	reg [`EDA_IRQ_W-1:0] irq_status;
	reg [`EDA_IRQ_W-1:0] irq_mask;
	reg mem_start;
	wire mem_busy;
	wire mem_done;
	wire [7:0] mem_rdata;
	wire wr_fire;
	wire wr_ok;
	wire wr_ctl;
	wire wr_unlock;
	wire wr_loc;
	wire wr_val;
	wire wr_sts;
	wire wr_msk;
	wire [7:0] nv_control;
	wire start_ok;
	wire op_busy;
	wire mem_abort;

	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready = !w_got && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_got && w_got && !s_axi_bvalid;
	assign wr_ok = wr_fire && w_lane;

	assign wr_ctl = wr_ok && aw_addr == `EDA_OFS_CONTROL;
	assign wr_unlock = wr_ok && aw_addr == `EDA_OFS_UNLOCK;
	assign wr_loc = wr_ok && aw_addr == `EDA_OFS_LOCATION;
	assign wr_val = wr_ok && aw_addr == `EDA_OFS_VALUE;
	assign wr_sts = wr_ok && aw_addr == `EDA_OFS_IRQ_STATUS;
	assign wr_msk = wr_ok && aw_addr == `EDA_OFS_IRQ_MASK;

	assign nv_control = {space_select, 3'h0, abort_flag, cycle_permit,
		pgo, fgo};
	assign op_busy = pgo || fgo;
	// A start issued on the same edge must be dropped as well
	assign mem_abort = warm_rst && (mem_busy || mem_start);

	// Old permit and a completed key sequence are both needed
	assign start_ok = wr_ctl && w_byte[`EDA_BIT_PGO] && !pgo && !fgo
		&& cycle_permit && unlock_state == `EDA_UNL_ARMED;

	assign irq = |(irq_status & irq_mask);

	eda_nvmem #(
		.WR_CYCLES(WR_CYCLES)
	) u_mem (
		.core_clk(core_clk),
		.nrst(nrst),
		.start(mem_start),
		.abort(mem_abort),
		.wr_addr(nv_location_reg),
		.wr_data(nv_value_reg),
		.busy(mem_busy),
		.done(mem_done),
		.rd_addr(nv_location_reg),
		.rd_data(mem_rdata)
	);

	// Write channel capture
	always @(posedge core_clk) begin
		if (!nrst) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= {`EDA_ADDR_W{1'b0}};
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `EDA_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == `EDA_OFS_CONTROL ||
					aw_addr == `EDA_OFS_UNLOCK ||
					aw_addr == `EDA_OFS_LOCATION ||
					aw_addr == `EDA_OFS_VALUE ||
					aw_addr == `EDA_OFS_IRQ_STATUS ||
					aw_addr == `EDA_OFS_IRQ_MASK) begin
					s_axi_bresp <= `EDA_RESP_OKAY;
				end else begin
					s_axi_bresp <= `EDA_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	always @(posedge core_clk) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `EDA_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `EDA_RESP_OKAY;
			if (s_axi_araddr == `EDA_OFS_CONTROL) begin
				s_axi_rdata <= {24'h000000, nv_control};
			end else if (s_axi_araddr == `EDA_OFS_UNLOCK) begin
				s_axi_rdata <= 32'h00000000;
			end else if (s_axi_araddr == `EDA_OFS_LOCATION) begin
				s_axi_rdata <= {24'h000000, nv_location_reg};
			end else if (s_axi_araddr == `EDA_OFS_VALUE) begin
				s_axi_rdata <= {24'h000000, nv_value_reg};
			end else if (s_axi_araddr == `EDA_OFS_IRQ_STATUS) begin
				s_axi_rdata <= {30'h00000000, irq_status};
			end else if (s_axi_araddr == `EDA_OFS_IRQ_MASK) begin
				s_axi_rdata <= {30'h00000000, irq_mask};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `EDA_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Unlock sequence tracker
	always @(posedge core_clk) begin
		if (!nrst || warm_rst) begin
			unlock_state <= `EDA_UNL_IDLE;
		end else if (wr_unlock) begin
			if (w_byte == `EDA_KEY_FIRST &&
				unlock_state == `EDA_UNL_IDLE) begin
				unlock_state <= `EDA_UNL_FIRST;
			end else if (w_byte == `EDA_KEY_SECOND &&
				unlock_state == `EDA_UNL_FIRST) begin
				unlock_state <= `EDA_UNL_ARMED;
			end else if (w_byte == `EDA_KEY_FIRST) begin
				unlock_state <= `EDA_UNL_FIRST;
			end else begin
				unlock_state <= `EDA_UNL_IDLE;
			end
		end else if (wr_ok) begin
			// Any other register write, including the go write itself
			unlock_state <= `EDA_UNL_IDLE;
		end
	end

	// Control register
	always @(posedge core_clk) begin
		if (!nrst) begin
			space_select <= 1'b0;
			abort_flag <= 1'b0;
			cycle_permit <= 1'b0;
			pgo <= 1'b0;
			fgo <= 1'b0;
			mem_start <= 1'b0;
			prog_rd_req <= 1'b0;
			prog_wr_req <= 1'b0;
			prog_addr <= 8'h00;
			prog_wdata <= 8'h00;
		end else if (warm_rst) begin
			space_select <= 1'b0;
			cycle_permit <= 1'b0;
			pgo <= 1'b0;
			fgo <= 1'b0;
			mem_start <= 1'b0;
			prog_rd_req <= 1'b0;
			prog_wr_req <= 1'b0;
			if (mem_busy || mem_start) begin
				abort_flag <= 1'b1;
			end
		end else begin
			mem_start <= 1'b0;
			prog_rd_req <= 1'b0;
			prog_wr_req <= 1'b0;
			// Read completes in one cycle
			if (fgo) begin
				fgo <= 1'b0;
			end
			if (mem_done) begin
				pgo <= 1'b0;
			end
			if (pgo && space_select && !mem_busy && !mem_start) begin
				pgo <= 1'b0;
			end
			if (wr_ctl) begin
				cycle_permit <= w_byte[`EDA_BIT_PERMIT];
				abort_flag <= w_byte[`EDA_BIT_ABORT];
				if (!op_busy) begin
					space_select <= w_byte[`EDA_BIT_SPACE];
				end
				if (start_ok) begin
					pgo <= 1'b1;
					if (space_select) begin
						prog_wr_req <= 1'b1;
						prog_addr <= nv_location_reg;
						prog_wdata <= nv_value_reg;
					end else begin
						mem_start <= 1'b1;
					end
				end else if (w_byte[`EDA_BIT_FGO] && !op_busy) begin
					fgo <= 1'b1;
					if (space_select) begin
						prog_rd_req <= 1'b1;
						prog_addr <= nv_location_reg;
					end
				end
			end
		end
	end

	// Location and value registers
	always @(posedge core_clk) begin
		if (!nrst) begin
			nv_location_reg <= 8'h00;
			nv_value_reg <= 8'h00;
		end else begin
			if (wr_loc) begin
				nv_location_reg <= w_byte;
			end
			if (fgo) begin
				if (space_select) begin
					nv_value_reg <= prog_rdata;
				end else begin
					nv_value_reg <= mem_rdata;
				end
			end else if (wr_val) begin
				nv_value_reg <= w_byte;
			end
		end
	end

	// Interrupt status and mask; hardware set wins over write-one clear
	always @(posedge core_clk) begin
		if (!nrst) begin
			irq_status <= {`EDA_IRQ_W{1'b0}};
			irq_mask <= {`EDA_IRQ_W{1'b0}};
		end else begin
			if (wr_sts) begin
				irq_status <= irq_status & ~w_byte[`EDA_IRQ_W-1:0];
			end
			if (mem_done) begin
				irq_status[`EDA_IRQ_DONE] <= 1'b1;
			end
			if (warm_rst && (mem_busy || mem_start)) begin
				irq_status[`EDA_IRQ_ABORT] <= 1'b1;
			end
			if (wr_msk) begin
				irq_mask <= w_byte[`EDA_IRQ_W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ---- eda_properties.sv ----
// Bus timing and pulse checks for the EEPROM data access block
`timescale 1ns/100ps
`default_nettype none
module eda_properties #(
	parameter WR_CYCLES = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Program route
	input wire logic prog_rd_req
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after capture");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read data not one cycle after capture");
	a_write_refused: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid)
		else $error("write response repeated");
	a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid)
		else $error("read data repeated");
	a_upper_zero: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_fetch_pulse: assert property (prog_rd_req |=> !prog_rd_req)
		else $error("program read request longer than one cycle");
endmodule
`default_nettype wire

// ---- test_eda_top.sv ----
// Self-checking bench for the EEPROM data access block
`timescale 1ns/100ps
`default_nettype none
`include "eda_consts.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_eda_top;
	localparam [7:0] CTL = `EDA_OFS_CONTROL;
	localparam [7:0] UNL = `EDA_OFS_UNLOCK;
	localparam [7:0] LOC = `EDA_OFS_LOCATION;
	localparam [7:0] VAL = `EDA_OFS_VALUE;
	localparam [7:0] STS = `EDA_OFS_IRQ_STATUS;
	localparam [7:0] MSK = `EDA_OFS_IRQ_MASK;
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic warm_rst = 1'h0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, prog_rdata = 8'hA5;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, ld;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, lr;
	logic prog_rd_req, prog_wr_req;
	logic [7:0] prog_addr, prog_wdata;
	integer pr_count = 0;
	integer pw_count = 0;
	integer miscompares = 0;
	integer samples_checked = 0;
	eda_top #(.WR_CYCLES(20)) i_dut (.core_clk, .nrst, .warm_rst,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.prog_rd_req, .prog_wr_req, .prog_addr, .prog_wdata,
		.prog_rdata, .irq);
	initial forever #12.5 core_clk = ~core_clk;
	// Count program-space request pulses
	always @(posedge core_clk) begin
		if (prog_rd_req) pr_count <= pr_count + 1;
		if (prog_wr_req) pw_count <= pw_count + 1;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic timeout();
		miscompares++;
		wrap_up();
	endtask
	task automatic wr(input [7:0] a, input [7:0] d);
		integer n;
		logic aw, w, b = 1'h0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 64 && !b; n++) begin
			@(negedge core_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
			if (b) s_axi_bready <= 1'h0;
		end
		if (!b) timeout();
	endtask
	task automatic rd(input [7:0] a);
		integer n;
		logic ar, r = 1'h0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 64 && !r; n++) begin
			@(negedge core_clk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			ld = s_axi_rdata;
			lr = s_axi_rresp;
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'h0;
			if (r) s_axi_rready <= 1'h0;
		end
		if (!r) timeout();
	endtask
	task automatic rc(input [7:0] a, input [31:0] e);
		rd(a);
		`CHK($sformatf("reg %h", a), e, ld)
	endtask
	task automatic ul();
		wr(UNL, `EDA_KEY_FIRST);
		wr(UNL, `EDA_KEY_SECOND);
	endtask
	task automatic t_reset();
		rc(CTL, '0);
		rc(STS, '0);
		rc(UNL, '0);
		rd(8'h18);
		`CHK("resp", `EDA_RESP_SLVERR, lr)
		`CHK("data", 32'h0, ld)
	endtask
	task automatic t_write();
		integer n;
		wr(MSK, 8'h01);
		wr(LOC, 8'h05);
		wr(VAL, 8'h3C);
		wr(CTL, 8'h04);
		ul();
		wr(CTL, 8'h06);
		wr(CTL, 8'h00);
		wr(CTL, 8'h80);
		rc(CTL, 32'h02);
		for (n = 0; n < 20 && ld[1] !== 1'h0; n++) rd(CTL);
		if (ld[1] !== 1'h0) timeout();
		rc(STS, 32'h01);
		#1;
		`CHK("irq", 1'h1, irq)
		wr(STS, 8'h01);
		#1;
		`CHK("irq", 1'h0, irq)
		wr(VAL, 8'h00);
		wr(CTL, 8'h01);
		rc(VAL, 32'h3C);
		rc(CTL, '0);
	endtask
	task automatic t_abort();
		wr(VAL, 8'h99);
		wr(CTL, 8'h04);
		ul();
		wr(CTL, 8'h06);
		warm_rst <= 1'h1;
		@(posedge core_clk);
		warm_rst <= 1'h0;
		rc(CTL, 32'h08);
		rc(STS, 32'h02);
		#1;
		`CHK("irq masked", 1'h0, irq)
		wr(MSK, 8'h03);
		#1;
		`CHK("irq", 1'h1, irq)
		wr(STS, 8'h02);
		wr(CTL, 8'h01);
		rc(VAL, 32'h3C);
	endtask
	task automatic t_lock();
		wr(CTL, 8'h00);
		ul();
		wr(CTL, 8'h06);
		rc(CTL, 32'h04);
		wr(CTL, 8'h00);
		ul();
		wr(CTL, 8'h02);
		rc(CTL, '0);
		wr(CTL, 8'h04);
		wr(UNL, `EDA_KEY_FIRST);
		wr(LOC, 8'h05);
		wr(UNL, `EDA_KEY_SECOND);
		wr(CTL, 8'h06);
		rc(CTL, 32'h04);
		rc(STS, '0);
	endtask
	task automatic t_prog();
		wr(CTL, 8'h80);
		wr(CTL, 8'h81);
		rc(VAL, {24'h0, prog_rdata});
		rc(CTL, 32'h80);
		`CHK("prog rd pulses", 1, pr_count)
		`CHK("prog addr", 8'h05, prog_addr)
		wr(VAL, 8'h5A);
		wr(CTL, 8'h84);
		ul();
		wr(CTL, 8'h86);
		rc(CTL, 32'h84);
		`CHK("prog wr pulses", 1, pw_count)
		`CHK("prog wdata", 8'h5A, prog_wdata)
		rc(STS, '0);
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'h1;
		t_reset();
		t_write();
		t_abort();
		t_lock();
		t_prog();
		wrap_up();
	end
endmodule
bind eda_top eda_properties #(.WR_CYCLES(WR_CYCLES)) i_chk (.core_clk,
	.nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .prog_rd_req);
`default_nettype wire
